// File: flash_row_erase_write_sequencer.sv
// Operation
// - Erase clears aligned 64-byte row, pointer bits 21:6
// - No word erase; no bulk erase from core
// - Erase needs program, not config, permit, erase select
// - Keys 55h then 0AAh must precede trigger
// - Core stalls; timer ends long write
// - Row erase stall about 2 ms
// - Block program stall about 2 ms
// - Programming always one whole 8-byte block
// - Table writes only load holding registers
// - Program needs program select, permit, no erase
// - External or watchdog reset mid-write sets abort
// - Table read fetches one byte into latch
// - Trigger only settable; hardware clears on completion
// - Hardware clears erase select after erase
// - Completion sets done flag; software clears it
// - Pointer 2:0 picks holding register; 21:3 block
`include "flash_seq_regs.svh"

module flash_row_erase_write_sequencer #(
  parameter int ERASE_CYCLES = `ERASE_TIME_US * 1000 / `CLK_PERIOD_NS,
  parameter int PROG_CYCLES = `PROG_TIME_US * 1000 / `CLK_PERIOD_NS,
  parameter int CNT_W = 20
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic ext_reset_req,
  input wire logic watchdog_timeout,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cpu_stall,
  output logic [`PTR_W-1:0] flash_addr,
  output logic flash_rd_en,
  input wire logic [7:0] flash_rdata,
  output logic flash_erase,
  output logic flash_prog,
  output logic [63:0] flash_wdata
);

  // ********************************************************
  // Register decode helpers
  // ********************************************************

  // True when the address names a mapped register
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `REG_CTRL_OFS) || (a == `REG_KEY_OFS) || (a == `REG_PTR_OFS) ||
                (a == `REG_LATCH_OFS) || (a == `REG_TABOP_OFS) || (a == `REG_STATUS_OFS);
  endfunction

  // Pointer after a step of the given direction
  function automatic logic [`PTR_W-1:0] ptr_step(input logic [`PTR_W-1:0] p,
                                                 input logic up);
    ptr_step = up ? p + `PTR_W'(1) : p - `PTR_W'(1);
  endfunction

  // ********************************************************
  // State
  // ********************************************************
  logic pgm_sel; // Program space select
  logic cfg_sel; // Config space select
  logic erase_sel; // Row erase select
  logic abort_flag; // Write abort flag
  logic permit; // Write permit
  logic wr_trig; // Write trigger
  logic done_flag; // Write done flag
  logic busy; // Long write running
  logic erasing; // Long write is an erase
  logic rd_pend; // Table read waiting for array data
  logic [`PTR_W-1:0] ptr; // Byte pointer
  logic [7:0] latch; // Table byte latch
  logic [7:0] hold [`HOLD_NUM]; // Holding registers
  flash_seq_pkg::key_state_t key_state; // Unlock progress

  // Next values
  logic next_pgm_sel, next_cfg_sel, next_erase_sel, next_abort_flag;
  logic next_permit, next_wr_trig, next_done_flag, next_busy, next_erasing;
  logic next_rd_pend, next_pready, next_pslverr, next_flash_rd_en;
  logic next_flash_erase, next_flash_prog;
  logic [`PTR_W-1:0] next_ptr, next_flash_addr;
  logic [7:0] next_latch;
  logic [7:0] next_hold [`HOLD_NUM];
  logic [31:0] next_prdata;
  logic [63:0] next_flash_wdata;
  flash_seq_pkg::key_state_t next_key_state;

  // ********************************************************
  // Bus qualifiers and timer
  // ********************************************************
  logic sreset; // Core reset that keeps the abort flag
  logic prep; // Access phase being answered
  logic commit; // Access completing this edge
  logic wcommit; // Write completing this edge
  logic start; // Long write launch
  logic timer_done; // Timer expiry pulse
  logic [CNT_W-1:0] timer_load; // Cycles for this operation
  logic [7:0] cmd_ctrl; // Written control byte
  flash_seq_pkg::ptr_mode_t op_mode; // Written pointer mode

  assign sreset = ext_reset_req | watchdog_timeout;
  assign prep = psel & penable & ~pready & ~busy & ~rd_pend;
  assign commit = psel & penable & pready;
  assign wcommit = commit & pwrite;
  assign cmd_ctrl = pwdata[7:0];
  assign op_mode = flash_seq_pkg::ptr_mode_t'(pwdata[`TABOP_MODE_LSB +: 2]);
  // Long write only after the full key pair and a valid setup
  assign start = wcommit && (paddr == `REG_CTRL_OFS) && cmd_ctrl[`CTRL_WR_BIT] &&
                 (key_state == flash_seq_pkg::KEY_ARMED) && cmd_ctrl[`CTRL_PGM_BIT] &&
                 !cmd_ctrl[`CTRL_CFG_BIT] && cmd_ctrl[`CTRL_PERMIT_BIT] && !sreset;
  // Each kind of long write has its own length
  assign timer_load = cmd_ctrl[`CTRL_ERASE_BIT] ? CNT_W'(ERASE_CYCLES) :
                      CNT_W'(PROG_CYCLES);

  // Internal programming timer
  prog_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .start(start),
    .load(timer_load),
    .abort(sreset),
    .done(timer_done)
  );

  // ********************************************************
  // Next state
  // ********************************************************

  // Register, unlock, table and long write behaviour
  always_comb begin
    next_pgm_sel = pgm_sel;
    next_cfg_sel = cfg_sel;
    next_erase_sel = erase_sel;
    next_abort_flag = abort_flag;
    next_permit = permit;
    next_wr_trig = wr_trig;
    next_done_flag = done_flag;
    next_busy = busy;
    next_erasing = erasing;
    next_rd_pend = 1'b0;
    next_ptr = ptr;
    next_latch = latch;
    next_hold = hold;
    next_key_state = key_state;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    next_flash_rd_en = 1'b0;
    next_flash_addr = flash_addr;
    next_flash_erase = 1'b0;
    next_flash_prog = 1'b0;
    next_flash_wdata = flash_wdata;
    // Answer a read or write one cycle into the access phase
    if (prep) begin
      next_pready = 1'b1;
      next_pslverr = !is_mapped(paddr);
      case (paddr)
        `REG_CTRL_OFS: next_prdata = {24'h000000, pgm_sel, cfg_sel, 1'b0, erase_sel,
                                      abort_flag, permit, wr_trig, 1'b0};
        `REG_PTR_OFS: next_prdata = {10'h000, ptr};
        `REG_LATCH_OFS: next_prdata = {24'h000000, latch};
        `REG_STATUS_OFS: next_prdata = {30'h00000000, busy, done_flag};
        default: next_prdata = 32'h00000000;
      endcase
    end
    // Unlock tracking: any completed access other than a key write in order breaks the chain
    if (commit) begin
      if (pwrite && paddr == `REG_KEY_OFS && cmd_ctrl == `KEY_FIRST) begin
        next_key_state = flash_seq_pkg::KEY_ONE;
      end else if (pwrite && paddr == `REG_KEY_OFS && cmd_ctrl == `KEY_SECOND &&
                   key_state == flash_seq_pkg::KEY_ONE) begin
        next_key_state = flash_seq_pkg::KEY_ARMED;
      end else begin
        next_key_state = flash_seq_pkg::KEY_IDLE;
      end
    end
    // Register writes
    if (wcommit) begin
      case (paddr)
        `REG_CTRL_OFS: begin
          next_pgm_sel = cmd_ctrl[`CTRL_PGM_BIT];
          next_cfg_sel = cmd_ctrl[`CTRL_CFG_BIT];
          next_erase_sel = cmd_ctrl[`CTRL_ERASE_BIT];
          next_permit = cmd_ctrl[`CTRL_PERMIT_BIT];
          // Abort flag is cleared by writing zero
          if (!cmd_ctrl[`CTRL_ABORT_BIT]) begin
            next_abort_flag = 1'b0;
          end
        end
        `REG_PTR_OFS: next_ptr = pwdata[`PTR_W-1:0];
        `REG_LATCH_OFS: next_latch = cmd_ctrl;
        `REG_TABOP_OFS: begin
          // Pre-increment moves the pointer before the access
          next_flash_addr = (op_mode == flash_seq_pkg::PTR_PRE_INC) ? ptr_step(ptr, 1'b1) : ptr;
          if (op_mode == flash_seq_pkg::PTR_PRE_INC || op_mode == flash_seq_pkg::PTR_POST_INC) begin
            next_ptr = ptr_step(ptr, 1'b1);
          end else if (op_mode == flash_seq_pkg::PTR_POST_DEC) begin
            next_ptr = ptr_step(ptr, 1'b0);
          end
          if (pwdata[`TABOP_RD_BIT]) begin
            // One byte from the array at the pointer
            next_flash_rd_en = 1'b1;
            next_rd_pend = 1'b1;
          end else if (pwdata[`TABOP_WR_BIT]) begin
            // Short write into one holding register only
            next_hold[next_flash_addr[`BLOCK_LSB-1:0]] = latch;
          end
        end
        `REG_STATUS_OFS: begin
          if (pwdata[`STAT_DONE_BIT]) begin
            next_done_flag = 1'b0;
          end
        end
        default: begin
          next_done_flag = done_flag;
        end
      endcase
    end
    // Array byte arrives the cycle after the read strobe; bus waits until then
    if (flash_rd_en) begin
      next_rd_pend = 1'b1;
    end else if (rd_pend) begin
      next_latch = flash_rdata;
    end
    // Launch the long write and stall the core
    if (start) begin
      next_wr_trig = 1'b1;
      next_busy = 1'b1;
      next_erasing = cmd_ctrl[`CTRL_ERASE_BIT];
      if (cmd_ctrl[`CTRL_ERASE_BIT]) begin
        // Row erase ignores the six low pointer bits
        next_flash_addr = {ptr[`PTR_W-1:`ROW_LSB], `ROW_LSB'(0)};
        next_flash_erase = 1'b1;
      end else begin
        // Whole block of eight held bytes
        next_flash_addr = {ptr[`PTR_W-1:`BLOCK_LSB], `BLOCK_LSB'(0)};
        next_flash_wdata = {hold[7], hold[6], hold[5], hold[4],
                            hold[3], hold[2], hold[1], hold[0]};
        next_flash_prog = 1'b1;
      end
    end
    // Timer expiry completes the operation
    if (timer_done && busy) begin
      next_busy = 1'b0;
      next_wr_trig = 1'b0;
      if (erasing) begin
        next_erase_sel = 1'b0;
      end
      next_done_flag = 1'b1;
    end
    // Core reset: abort flag records an interrupted write
    if (sreset) begin
      if (busy) begin
        next_abort_flag = 1'b1;
      end
      next_erase_sel = 1'b0;
      next_permit = 1'b0;
      next_wr_trig = 1'b0;
      next_done_flag = 1'b0;
      next_busy = 1'b0;
      next_erasing = 1'b0;
      next_rd_pend = 1'b0;
      next_ptr = '0;
      next_latch = 8'h00;
      next_key_state = flash_seq_pkg::KEY_IDLE;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_flash_rd_en = 1'b0;
      next_flash_erase = 1'b0;
      next_flash_prog = 1'b0;
    end
  end

  // ********************************************************
  // Registers
  // ********************************************************

  // Power-on reset clears everything except the holding registers, which load FFh
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pgm_sel <= 1'b0;
      cfg_sel <= 1'b0;
      erase_sel <= 1'b0;
      abort_flag <= 1'b0;
      permit <= 1'b0;
      wr_trig <= 1'b0;
      done_flag <= 1'b0;
      busy <= 1'b0;
      erasing <= 1'b0;
      rd_pend <= 1'b0;
      ptr <= '0;
      latch <= 8'h00;
      hold <= '{default: 8'hff};
      key_state <= flash_seq_pkg::KEY_IDLE;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cpu_stall <= 1'b0;
      flash_addr <= '0;
      flash_rd_en <= 1'b0;
      flash_erase <= 1'b0;
      flash_prog <= 1'b0;
      flash_wdata <= 64'h0000000000000000;
    end else if (ce) begin
      pgm_sel <= next_pgm_sel;
      cfg_sel <= next_cfg_sel;
      erase_sel <= next_erase_sel;
      abort_flag <= next_abort_flag;
      permit <= next_permit;
      wr_trig <= next_wr_trig;
      done_flag <= next_done_flag;
      busy <= next_busy;
      erasing <= next_erasing;
      rd_pend <= next_rd_pend;
      ptr <= next_ptr;
      latch <= next_latch;
      hold <= next_hold;
      key_state <= next_key_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      cpu_stall <= next_busy;
      flash_addr <= next_flash_addr;
      flash_rd_en <= next_flash_rd_en;
      flash_erase <= next_flash_erase;
      flash_prog <= next_flash_prog;
      flash_wdata <= next_flash_wdata;
    end
  end

endmodule

// File: flash_seq_regs.svh
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH

// ********************************************************
// Register byte offsets
// ********************************************************
`define REG_CTRL_OFS 8'h00
`define REG_KEY_OFS 8'h04
`define REG_PTR_OFS 8'h08
`define REG_LATCH_OFS 8'h0c
`define REG_TABOP_OFS 8'h10
`define REG_STATUS_OFS 8'h14

// ********************************************************
// Control register fields
// ********************************************************
`define CTRL_PGM_BIT 7
`define CTRL_CFG_BIT 6
`define CTRL_ERASE_BIT 4
`define CTRL_ABORT_BIT 3
`define CTRL_PERMIT_BIT 2
`define CTRL_WR_BIT 1

// ********************************************************
// Table operation and status fields
// ********************************************************
`define TABOP_RD_BIT 0
`define TABOP_WR_BIT 1
`define TABOP_MODE_LSB 2
`define STAT_DONE_BIT 0
`define STAT_BUSY_BIT 1

// ********************************************************
// Unlock keys and widths
// ********************************************************
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
`define PTR_W 22
`define ROW_LSB 6
`define BLOCK_LSB 3
`define HOLD_NUM 8

// ********************************************************
// Timing
// ********************************************************
`define CLK_PERIOD_NS 20
`define ERASE_TIME_US 2000
`define PROG_TIME_US 2000

`endif

// File: flash_seq_pkg.sv
package flash_seq_pkg;

  // Unlock key progress
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_ONE,
    KEY_ARMED
  } key_state_t;

  // Pointer update around a table operation
  typedef enum logic [1:0] {
    PTR_KEEP,
    PTR_POST_INC,
    PTR_POST_DEC,
    PTR_PRE_INC
  } ptr_mode_t;

endpackage

// File: prog_timer.sv
`include "flash_seq_regs.svh"

module prog_timer #(
  parameter int CNT_W = 20
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [CNT_W-1:0] load,
  input wire logic abort,
  output logic done
);

  // ********************************************************
  // Countdown state
  // ********************************************************
  logic [CNT_W-1:0] count; // Cycles left
  logic running; // Timer active
  logic [CNT_W-1:0] next_count;
  logic next_running;
  logic next_done;

  // Next value of the countdown
  always_comb begin
    next_count = count;
    next_running = running;
    next_done = 1'b0;
    if (abort) begin
      // A reset of the core kills the operation
      next_running = 1'b0;
      next_count = '0;
    end else if (start) begin
      next_running = 1'b1;
      next_count = load;
    end else if (running) begin
      if (count <= CNT_W'(1)) begin
        // Expiry ends the long write
        next_running = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count - CNT_W'(1);
      end
    end
  end

  // Register the countdown
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      count <= next_count;
      running <= next_running;
      done <= next_done;
    end
  end

endmodule

// File: flash_seq_checker.sv
// ********
// Port-level checks for the row erase and block program sequencer
// ********
module flash_seq_checker #(
  parameter int ERASE_CYCLES = 20,
  parameter int PROG_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic ext_reset_req,
  input wire logic watchdog_timeout,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_stall,
  input wire logic [21:0] flash_addr,
  input wire logic flash_rd_en,
  input wire logic flash_erase,
  input wire logic flash_prog
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shortest and longest stall that still counts as a timed operation
  localparam int LO = (ERASE_CYCLES < PROG_CYCLES ? ERASE_CYCLES : PROG_CYCLES) - 1;
  localparam int HI = (ERASE_CYCLES > PROG_CYCLES ? ERASE_CYCLES : PROG_CYCLES) + 3;
  logic [31:0] stall_cnt; // Enabled cycles of the current stall
  logic [31:0] next_stall_cnt;
  logic cut; // Stall was cut short by a core reset
  logic next_cut;

  // Count stall length; remember a core reset seen during it
  always_comb begin
    next_stall_cnt = cpu_stall ? stall_cnt + {31'h0, ce} : 32'h0;
    next_cut = cpu_stall & (cut | ext_reset_req | watchdog_timeout);
  end

  // Register the helper state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stall_cnt <= 32'h0;
      cut <= 1'b0;
    end else begin
      stall_cnt <= next_stall_cnt;
      cut <= next_cut;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_erase_row; flash_erase |-> flash_addr[5:0] == 6'h00; endproperty
  a_erase_row: assert property (p_erase_row)
    else $error("erase address not row aligned");
  property p_prog_block; flash_prog |-> flash_addr[2:0] == 3'h0 && !flash_erase; endproperty
  a_prog_block: assert property (p_prog_block)
    else $error("program address not block aligned");
  property p_start_stalls; (flash_erase || flash_prog) |-> cpu_stall ##1 cpu_stall; endproperty
  a_start_stalls: assert property (p_start_stalls)
    else $error("long write did not stall the core");
  property p_start_idle; (flash_erase || flash_prog) |-> !$past(cpu_stall); endproperty
  a_start_idle: assert property (p_start_idle)
    else $error("long write started during a stall");
  property p_stall_min; $fell(cpu_stall) && !cut |-> stall_cnt >= LO; endproperty
  a_stall_min: assert property (p_stall_min)
    else $error("stall ended early");
  property p_stall_max; cpu_stall |-> stall_cnt <= HI; endproperty
  a_stall_max: assert property (p_stall_max)
    else $error("stall lasted too long");
  property p_stall_blocks; cpu_stall |-> !pready; endproperty
  a_stall_blocks: assert property (p_stall_blocks)
    else $error("bus answered during a stall");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held longer than one cycle");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready");
  property p_rd_pulse; flash_rd_en |=> !flash_rd_en; endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("array read longer than one byte");

  c_erase: cover property (flash_erase);
  c_prog: cover property (flash_prog);
  c_abort: cover property (cpu_stall && (ext_reset_req || watchdog_timeout));
endmodule

bind flash_row_erase_write_sequencer flash_seq_checker #(
  .ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES(PROG_CYCLES)
) u_chk (
  .ref_clk(ref_clk), .rst(rst), .ce(ce), .ext_reset_req(ext_reset_req),
  .watchdog_timeout(watchdog_timeout), .pready(pready), .pslverr(pslverr),
  .cpu_stall(cpu_stall), .flash_addr(flash_addr), .flash_rd_en(flash_rd_en),
  .flash_erase(flash_erase), .flash_prog(flash_prog)
);

// File: test_flash_row_erase_write_sequencer.sv
`include "flash_seq_regs.svh"
module test_flash_row_erase_write_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Stimulus and observed signals
  // ********
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1; // Clock enable kept running
  logic ext_reset_req = 1'b0;
  logic watchdog_timeout = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cpu_stall, flash_rd_en, flash_erase, flash_prog;
  logic [21:0] flash_addr;
  logic [7:0] flash_rdata = 8'h00; // Array model read byte
  logic [63:0] flash_wdata, prog_data, exp_data;
  logic [21:0] er_addr, pg_addr; // Address seen at each start pulse
  logic [31:0] rval; // Last read data
  logic rerr; // Last error response
  logic [31:0] pexp [4] = '{32'h100, 32'h101, 32'h0ff, 32'h101};
  int n_er = 0, n_pg = 0, n_rd = 0, mismatches = 0, compares = 0, cyc = 0;

  flash_row_erase_write_sequencer #(.ERASE_CYCLES(20), .PROG_CYCLES(20), .CNT_W(20)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .ext_reset_req(ext_reset_req),
    .watchdog_timeout(watchdog_timeout), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall), .flash_addr(flash_addr),
    .flash_rd_en(flash_rd_en), .flash_rdata(flash_rdata), .flash_erase(flash_erase),
    .flash_prog(flash_prog), .flash_wdata(flash_wdata)
  );

  always #10 ref_clk = ~ref_clk;

  // Array model, start pulse monitor and hang limit
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    flash_rdata <= flash_addr[7:0] ^ 8'h5a;
    // Count array read strobes
    if (flash_rd_en) begin
      n_rd <= n_rd + 1;
    end
    if (flash_erase) begin
      n_er <= n_er + 1;
      er_addr <= flash_addr;
    end
    if (flash_prog) begin
      n_pg <= n_pg + 1;
      pg_addr <= flash_addr;
      prog_data <= flash_wdata;
    end
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end

  // ********
  // Tasks
  // ********
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One bus transfer: setup, then access until ready
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rval = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(64'(rval), 64'(exp));
  endtask

  // Key pair, then the control write with the trigger
  task automatic go(input logic [31:0] c);
    apb(`REG_KEY_OFS, 1'b1, {24'h0, `KEY_FIRST});
    apb(`REG_KEY_OFS, 1'b1, {24'h0, `KEY_SECOND});
    apb(`REG_CTRL_OFS, 1'b1, c);
  endtask

  task automatic summarize();
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ********
  // Test sequence
  // ********
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`REG_CTRL_OFS, 32'h0);
    rd(`REG_STATUS_OFS, 32'h0);
    rd(`REG_KEY_OFS, 32'h0);
    rd(8'h18, 32'h0);
    chk(64'(rerr), 64'h1);
    // Triggers without a clean unlock or with a wrong setup
    apb(`REG_PTR_OFS, 1'b1, 32'h12a7f);
    apb(`REG_CTRL_OFS, 1'b1, 32'h96);
    apb(`REG_KEY_OFS, 1'b1, {24'h0, `KEY_FIRST});
    rd(`REG_CTRL_OFS, 32'h94);
    apb(`REG_KEY_OFS, 1'b1, {24'h0, `KEY_SECOND});
    apb(`REG_CTRL_OFS, 1'b1, 32'h96);
    go(32'hd6);
    go(32'h92);
    go(32'h16);
    chk(64'(n_er + n_pg), 64'h0);
    // Row erase
    go(32'h96);
    rd(`REG_STATUS_OFS, 32'h1);
    chk(64'(n_er), 64'h1);
    chk(64'(er_addr), 64'h12a40);
    rd(`REG_CTRL_OFS, 32'h84);
    rd(`REG_STATUS_OFS, 32'h1);
    apb(`REG_STATUS_OFS, 1'b1, 32'h1);
    rd(`REG_STATUS_OFS, 32'h0);
    // Fill the holding registers, then program the block
    apb(`REG_PTR_OFS, 1'b1, 32'h12a40);
    for (int i = 0; i < 8; i++) begin
      exp_data[8*i+:8] = 8'hc3 + 8'(i * 17);
      apb(`REG_LATCH_OFS, 1'b1, {24'h0, exp_data[8*i+:8]});
      apb(`REG_TABOP_OFS, 1'b1, 32'h6);
    end
    chk(64'(n_pg), 64'h0);
    rd(`REG_PTR_OFS, 32'h12a48);
    apb(`REG_PTR_OFS, 1'b1, 32'h12a45);
    go(32'h86);
    rd(`REG_STATUS_OFS, 32'h1);
    chk(64'(pg_addr), 64'h12a40);
    chk(prog_data, exp_data);
    apb(`REG_CTRL_OFS, 1'b1, 32'h86);
    chk(64'(n_pg), 64'h1);
    // Table reads in every pointer mode
    for (int m = 0; m < 4; m++) begin
      apb(`REG_PTR_OFS, 1'b1, 32'h100);
      apb(`REG_TABOP_OFS, 1'b1, 32'(m * 4 + 1));
      rd(`REG_LATCH_OFS, {24'h0, (m == 3 ? 8'h01 : 8'h00) ^ 8'h5a});
      rd(`REG_PTR_OFS, pexp[m]);
    end
    chk(64'(n_rd), 64'h4);
    // Core reset from each source during an erase
    for (int s = 0; s < 2; s++) begin
      apb(`REG_PTR_OFS, 1'b1, 32'h40);
      go(32'h96);
      repeat (5) @(posedge ref_clk);
      if (s == 0) begin
        ext_reset_req <= 1'b1;
      end else begin
        watchdog_timeout <= 1'b1;
      end
      @(posedge ref_clk);
      ext_reset_req <= 1'b0;
      watchdog_timeout <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(64'(cpu_stall), 64'h0);
      rd(`REG_CTRL_OFS, 32'h88);
      rd(`REG_STATUS_OFS, 32'h0);
      apb(`REG_CTRL_OFS, 1'b1, 32'h80);
      rd(`REG_CTRL_OFS, 32'h80);
    end
    summarize();
  end
endmodule
